// ===== shared/ppd_pkg.sv
// Purpose: Constants for the PLL power-down register bank
// Assumes: 32-bit AHB-Lite data, one register per word
// Notes: Byte address is four times the register index
//
// Operation
// (RQ1) Manual VCO select, three bits, resets 001
// (RQ2) Manual lock code, five bits, resets 01011
// (RQ3) Software writes reserved bits as zero
// (RQ4) Alarm clears on lock, or lock+stable
// (RQ5) Doubler off bit feeds crystal unchanged
// (RQ6) Output off bit disables pair, driver float
// (RQ7) Modulator off bit stops delta-sigma modulator
// (RQ8) Calibration reset bit holds calibration in reset
// (RQ9) Reference off bits disable reference inputs
// (RQ10) Digital loop off bit disables digital PLL
package ppd_pkg;

    // ************************************************
    // Register indices
    // ************************************************
    localparam logic [7:0] IDX_VCO = 8'h6A;
    localparam logic [7:0] IDX_LCK = 8'h6C;
    localparam logic [7:0] IDX_REF = 8'h6D;
    localparam logic [7:0] IDX_RSV = 8'h6E;
    localparam logic [7:0] IDX_OUT = 8'h6F;
    localparam logic [7:0] IDX_SUB = 8'h70;
    localparam logic [7:0] IDX_IST = 8'h80;
    localparam logic [7:0] IDX_IEN = 8'h81;
    localparam logic [7:0] IDX_ICL = 8'h82;
    localparam logic [7:0] IDX_LIVE = 8'h83;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int POS_VCO = 5;
    localparam int POS_CODE = 0;
    localparam int POS_DBL = 0;
    localparam int POS_LMODE = 1;
    localparam int POS_CAL = 1;
    localparam int POS_DSM = 2;
    localparam int POS_DPLL = 3;
    localparam int POS_EV_SET = 0;
    localparam int POS_EV_CLR = 1;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [2:0] RST_VCO = 3'h1;
    localparam logic [4:0] RST_CODE = 5'h0B;
    localparam logic RST_BIT = 1'h0;
    localparam logic RST_ALARM = 1'h1;

endpackage

// ===== rtl/ppd_lol_track.sv
// Purpose: Loss-of-lock alarm with programmable release
// Assumes: Lock and stable inputs synchronous to hclk
// Notes: Alarm is raised at reset until lock, or lock and stable when lock_alarm_mode is set
`timescale 1ns/1ps
`default_nettype none
module ppd_lol_track (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control and status
    input wire logic lock_alarm_mode,
    input wire logic pll_locked,
    input wire logic outputs_stable,
    // Alarm and events
    output logic alarm,
    output logic ev_set,
    output logic ev_clr
);
    typedef struct packed {
        logic alarm;
        logic ev_set;
        logic ev_clr;
    } ppd_lol_t;

    ppd_lol_t st;
    ppd_lol_t next_st;
    logic release_ok;

    always_comb begin
        next_st = st;
        release_ok = pll_locked && (!lock_alarm_mode || outputs_stable); // RQ4
        if (!pll_locked) begin
            next_st.alarm = 1'h1;
        end else if (release_ok) begin
            next_st.alarm = 1'h0; // RQ4
        end
        next_st.ev_set = next_st.alarm && !st.alarm;
        next_st.ev_clr = !next_st.alarm && st.alarm;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{alarm: ppd_pkg::RST_ALARM, ev_set: 1'h0, ev_clr: 1'h0};
        end else begin
            st <= next_st;
        end
    end

    assign alarm = st.alarm;
    assign ev_set = st.ev_set;
    assign ev_clr = st.ev_clr;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_alarm_hold_mode: assert property ( // RQ4
        (lock_alarm_mode && pll_locked && !outputs_stable && alarm) |=> alarm)
        else $error("alarm released before outputs stable");
    a_alarm_release: assert property ( // RQ4
        (pll_locked && !lock_alarm_mode) |=> !alarm)
        else $error("alarm not released on lock");
    a_alarm_raise: assert property (
        (!pll_locked && !alarm) |=> (alarm && ev_set))
        else $error("alarm not raised on unlock");
endmodule // ppd_lol_track
`default_nettype wire

// ===== rtl/ppd_regs.sv
// Purpose: AHB-Lite register bank for PLL power-down control
// Assumes: Single word transfers, one slave on the bus
// Notes: Every transfer takes one wait state
`timescale 1ns/1ps
`default_nettype none
module ppd_regs #(
    parameter int NUM_OUTPUTS = 4,
    parameter int NUM_REFS = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // PLL status in
    input wire logic pll_locked,
    input wire logic outputs_stable,
    // Analog PLL controls
    output logic [2:0] manual_vco_select,
    output logic [4:0] manual_lock_code,
    output logic crystal_doubler_off,
    output logic modulator_off,
    output logic calibration_reset,
    output logic digital_loop_off,
    // Inputs and outputs gating
    output logic [NUM_REFS-1:0] ref_input_off,
    output logic [NUM_OUTPUTS-1:0] output_pair_off,
    output logic [NUM_OUTPUTS-1:0] out_drive_en,
    // Alarm and interrupt
    output logic loss_of_lock_alarm,
    output logic irq
);

    // ************************************************
    // Elaboration checks
    // ************************************************
    if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 4) begin : g_bad_out
        $error("NUM_OUTPUTS must be 1 to 4");
    end
    if (NUM_REFS < 1 || NUM_REFS > 2) begin : g_bad_ref
        $error("NUM_REFS must be 1 to 2");
    end

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic pend;
        logic pwrite;
        logic [7:0] pidx;
        logic pmap;
        logic readyout;
        logic resp;
        logic [31:0] rdata;
        logic [2:0] vco;
        logic [4:0] code;
        logic lmode;
        logic dbl;
        logic [NUM_REFS-1:0] refoff;
        logic [NUM_OUTPUTS-1:0] outoff;
        logic [NUM_OUTPUTS-1:0] drive;
        logic dpll;
        logic dsm;
        logic cal;
        logic [1:0] ist;
        logic [1:0] ien;
        logic irq;
    } ppd_state_t;

    ppd_state_t st;
    ppd_state_t next_st;

    logic accept;
    logic wr_now;
    logic rd_now;
    logic alarm;
    logic ev_set;
    logic ev_clr;
    logic [1:0] events;
    logic [1:0] clr_bits;
    logic [31:0] rd_mux;
    logic [7:0] wb;

    // ************************************************
    // Alarm tracker
    // ************************************************
    ppd_lol_track u_lol (
        .hclk(hclk),
        .hresetn(hresetn),
        .lock_alarm_mode(st.lmode),
        .pll_locked(pll_locked),
        .outputs_stable(outputs_stable),
        .alarm(alarm),
        .ev_set(ev_set),
        .ev_clr(ev_clr)
    );

    // ************************************************
    // Read mux
    // ************************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (st.pmap) begin
            case (st.pidx)
                ppd_pkg::IDX_VCO: begin
                    rd_mux[ppd_pkg::POS_VCO +: 3] = st.vco; // RQ1
                    rd_mux[ppd_pkg::POS_CODE +: 5] = st.code; // RQ2
                end
                ppd_pkg::IDX_LCK: begin
                    rd_mux[ppd_pkg::POS_LMODE] = st.lmode;
                    rd_mux[ppd_pkg::POS_DBL] = st.dbl;
                end
                ppd_pkg::IDX_REF: begin
                    rd_mux[NUM_REFS-1:0] = st.refoff;
                end
                ppd_pkg::IDX_OUT: begin
                    rd_mux[NUM_OUTPUTS-1:0] = st.outoff;
                end
                ppd_pkg::IDX_SUB: begin
                    rd_mux[ppd_pkg::POS_DPLL] = st.dpll;
                    rd_mux[ppd_pkg::POS_DSM] = st.dsm;
                    rd_mux[ppd_pkg::POS_CAL] = st.cal;
                end
                ppd_pkg::IDX_IST: begin
                    rd_mux[1:0] = st.ist;
                end
                ppd_pkg::IDX_IEN: begin
                    rd_mux[1:0] = st.ien;
                end
                ppd_pkg::IDX_LIVE: begin
                    rd_mux[0] = alarm;
                end
                default: begin
                    // Reserved and write-only words read zero (RQ3)
                    rd_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        next_st = st;
        accept = hsel && htrans[1] && hready;
        wr_now = st.pend && st.pwrite && st.pmap;
        rd_now = st.pend && !st.pwrite;
        wb = hwdata[7:0];
        events = 2'h0;
        events[ppd_pkg::POS_EV_SET] = ev_set;
        events[ppd_pkg::POS_EV_CLR] = ev_clr;
        clr_bits = 2'h0;
        next_st.resp = 1'h0;

        // Address phase capture, data phase after a wait state
        if (accept) begin
            next_st.pend = 1'h1;
            next_st.pwrite = hwrite;
            next_st.pidx = haddr[9:2];
            next_st.pmap = (haddr[31:10] == 22'h00_0000);
            next_st.readyout = 1'h0;
        end else if (st.pend) begin
            next_st.pend = 1'h0;
            next_st.readyout = 1'h1;
        end
        if (rd_now) begin
            next_st.rdata = rd_mux;
        end

        if (wr_now) begin
            case (st.pidx)
                ppd_pkg::IDX_VCO: begin
                    next_st.vco = wb[ppd_pkg::POS_VCO +: 3]; // RQ1
                    next_st.code = wb[ppd_pkg::POS_CODE +: 5]; // RQ2
                end
                ppd_pkg::IDX_LCK: begin
                    next_st.lmode = wb[ppd_pkg::POS_LMODE]; // RQ4
                    next_st.dbl = wb[ppd_pkg::POS_DBL]; // RQ5
                end
                ppd_pkg::IDX_REF: begin
                    next_st.refoff = wb[NUM_REFS-1:0]; // RQ9
                end
                ppd_pkg::IDX_OUT: begin
                    next_st.outoff = wb[NUM_OUTPUTS-1:0]; // RQ6
                end
                ppd_pkg::IDX_SUB: begin
                    next_st.dpll = wb[ppd_pkg::POS_DPLL]; // RQ10
                    next_st.dsm = wb[ppd_pkg::POS_DSM]; // RQ7
                    next_st.cal = wb[ppd_pkg::POS_CAL]; // RQ8
                end
                ppd_pkg::IDX_IEN: begin
                    next_st.ien = wb[1:0];
                end
                ppd_pkg::IDX_ICL: begin
                    clr_bits = wb[1:0];
                end
                default: begin
                    clr_bits = 2'h0;
                end
            endcase
        end

        // Disabled pairs release their drivers
        next_st.drive = ~next_st.outoff; // RQ6
        // An event in the clearing cycle survives
        next_st.ist = (st.ist & ~clr_bits) | events;
        next_st.irq = |(next_st.ist & next_st.ien);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.readyout <= 1'h1;
            st.vco <= ppd_pkg::RST_VCO; // RQ1
            st.code <= ppd_pkg::RST_CODE; // RQ2
            st.lmode <= ppd_pkg::RST_BIT;
            st.dbl <= ppd_pkg::RST_BIT;
            st.dpll <= ppd_pkg::RST_BIT;
            st.dsm <= ppd_pkg::RST_BIT;
            st.cal <= ppd_pkg::RST_BIT;
            st.drive <= '1;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign hreadyout = st.readyout;
    assign hresp = st.resp;
    assign hrdata = st.rdata;
    assign manual_vco_select = st.vco;
    assign manual_lock_code = st.code;
    assign crystal_doubler_off = st.dbl;
    assign modulator_off = st.dsm;
    assign calibration_reset = st.cal;
    assign digital_loop_off = st.dpll;
    assign ref_input_off = st.refoff;
    assign output_pair_off = st.outoff;
    assign out_drive_en = st.drive;
    assign loss_of_lock_alarm = alarm;
    assign irq = st.irq;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_take;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_wait_done;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_wr(logic [7:0] idx);
        s_take ##0 (hwrite && haddr[31:10] == 22'h0 && haddr[9:2] == idx);
    endsequence

    a_wait_state: assert property (
        s_take |=> s_wait_done)
        else $error("transfer not answered after one wait state");
    a_resp_okay: assert property (
        !hresp)
        else $error("error response driven");
    a_vco_write: assert property ( // RQ1
        s_wr(ppd_pkg::IDX_VCO) ##1 1'b1 |=> (manual_vco_select == $past(hwdata[7:5])))
        else $error("vco select not updated by write");
    a_code_write: assert property ( // RQ2
        s_wr(ppd_pkg::IDX_VCO) ##1 1'b1 |=> (manual_lock_code == $past(hwdata[4:0])))
        else $error("lock code not updated by write");
    a_sub_write: assert property ( // RQ8
        s_wr(ppd_pkg::IDX_SUB) ##1 1'b1 |=> (calibration_reset == $past(hwdata[1])))
        else $error("calibration reset not updated by write");
    a_drive_off: assert property ( // RQ6
        out_drive_en == ~output_pair_off)
        else $error("driver enabled on a disabled pair");
    a_irq_level: assert property (
        irq == |(st.ist & st.ien))
        else $error("interrupt level mismatch");
    a_set_wins: assert property (
        (ev_set && wr_now && st.pidx == ppd_pkg::IDX_ICL) |=> st.ist[0])
        else $error("event lost under clear");
    a_unmapped_zero: assert property ( // RQ3
        (rd_now && !st.pmap) |=> (hrdata == 32'h0000_0000))
        else $error("unmapped read not zero");
    a_mode_hold: assert property ( // RQ7
        (!wr_now) |=> $stable(modulator_off))
        else $error("modulator control changed without write");

endmodule // ppd_regs
`default_nettype wire

// ===== sim/tb.sv
// Purpose: Self-checking bench for the PLL power-down register bank
// Assumes: AHB-Lite single word transfers, hready taken from hreadyout
// Notes: Expected values come from field layout and reset values
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ************************************************
    // Stimulus and observed signals
    // ************************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic pll_locked = 1'b0;
    logic outputs_stable = 1'b0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [2:0] manual_vco_select;
    wire logic [4:0] manual_lock_code;
    wire logic crystal_doubler_off;
    wire logic modulator_off;
    wire logic calibration_reset;
    wire logic digital_loop_off;
    wire logic [1:0] ref_input_off;
    wire logic [3:0] output_pair_off;
    wire logic [3:0] out_drive_en;
    wire logic loss_of_lock_alarm;
    wire logic irq;
    wire logic [21:0] pv;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] idx_tab [8] = '{ppd_pkg::IDX_VCO, ppd_pkg::IDX_LCK, ppd_pkg::IDX_REF, ppd_pkg::IDX_RSV,
        ppd_pkg::IDX_OUT, ppd_pkg::IDX_SUB, ppd_pkg::IDX_IEN, ppd_pkg::IDX_LIVE};
    logic [7:0] rst_tab [8] = '{8'h2B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0] ones_tab [8] = '{8'hFF, 8'h03, 8'h03, 8'h00, 8'h0F, 8'h0E, 8'h03, 8'h01};

    // Control outputs packed for one compare
    assign pv = {manual_vco_select, manual_lock_code, digital_loop_off, modulator_off, calibration_reset,
        crystal_doubler_off, ref_input_off, output_pair_off, out_drive_en};

    always #50 hclk = ~hclk;

    ppd_regs ppd_regs_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .pll_locked(pll_locked),
        .outputs_stable(outputs_stable),
        .manual_vco_select(manual_vco_select),
        .manual_lock_code(manual_lock_code),
        .crystal_doubler_off(crystal_doubler_off),
        .modulator_off(modulator_off),
        .calibration_reset(calibration_reset),
        .digital_loop_off(digital_loop_off),
        .ref_input_off(ref_input_off),
        .output_pair_off(output_pair_off),
        .out_drive_en(out_drive_en),
        .loss_of_lock_alarm(loss_of_lock_alarm),
        .irq(irq)
    );

    // ************************************************
    // Tasks
    // ************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One transfer; returns at the edge that ends the data phase
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] junk;
        xfer({22'h0, idx, 2'h0}, 1'b1, d, junk);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h0, v);
        check(v, exp, msg);
        check(hresp, 1'b0, "okay response");
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // ************************************************
    // Timeout
    // ************************************************
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        step(16);
        hresetn <= 1'b1;
        check(pv, {8'h2B, 4'h0, 2'h0, 4'h0, 4'hF}, "reset outputs");
        check({loss_of_lock_alarm, irq}, 2'h2, "reset alarm");
        for (int i = 0; i < 8; i++) begin
            rd_chk({22'h0, idx_tab[i], 2'h0}, {24'h0, rst_tab[i]}, "reset read");
        end
        $display("test reset values done");

        for (int i = 0; i < 8; i++) begin
            wr(idx_tab[i], {24'h0, ones_tab[i]});
        end
        for (int i = 0; i < 8; i++) begin
            rd_chk({22'h0, idx_tab[i], 2'h0}, {24'h0, ones_tab[i]}, "ones read");
        end
        check(pv, {8'hFF, 4'hF, 2'h3, 4'hF, 4'h0}, "ones outputs");
        wr(8'hFF, 32'h0000_00FF);
        rd_chk(32'h0000_0400, 32'h0, "unmapped read");
        rd_chk({22'h0, ppd_pkg::IDX_VCO, 2'h0}, 32'hFF, "vco after unmapped");
        for (int i = 0; i < 7; i++) begin
            wr(idx_tab[i], 32'h0);
        end
        check(pv, {8'h00, 4'h0, 2'h0, 4'h0, 4'hF}, "zero outputs");
        wr(ppd_pkg::IDX_VCO, 32'h2B);
        check(pv[21:14], 8'h2B, "vco one code");
        $display("test field access done");

        wr(ppd_pkg::IDX_ICL, 32'h3);
        rd_chk({22'h0, ppd_pkg::IDX_IST, 2'h0}, 32'h0, "status cleared");
        rd_chk({22'h0, ppd_pkg::IDX_ICL, 2'h0}, 32'h0, "clear reads zero");
        wr(ppd_pkg::IDX_IEN, 32'h2);
        pll_locked <= 1'b1;
        step(4);
        check(loss_of_lock_alarm, 1'b0, "mode0 release on lock");
        check(irq, 1'b1, "irq on release");
        rd_chk({22'h0, ppd_pkg::IDX_IST, 2'h0}, 32'h2, "release event");
        rd_chk({22'h0, ppd_pkg::IDX_LIVE, 2'h0}, 32'h0, "live clear");
        wr(ppd_pkg::IDX_ICL, 32'h2);
        check(irq, 1'b0, "irq cleared");
        pll_locked <= 1'b0;
        step(4);
        check(loss_of_lock_alarm, 1'b1, "alarm on unlock");
        check(irq, 1'b0, "masked set event");
        rd_chk({22'h0, ppd_pkg::IDX_IST, 2'h0}, 32'h1, "set event");
        wr(ppd_pkg::IDX_LCK, 32'h2);
        pll_locked <= 1'b1;
        step(4);
        check(loss_of_lock_alarm, 1'b1, "mode1 waits stable");
        check(irq, 1'b0, "no release yet");
        outputs_stable <= 1'b1;
        step(4);
        check(loss_of_lock_alarm, 1'b0, "mode1 release");
        check(irq, 1'b1, "irq mode1 release");
        // Unlock event lands in the same cycle as its clear
        pll_locked <= 1'b0;
        wr(ppd_pkg::IDX_ICL, 32'h1);
        rd_chk({22'h0, ppd_pkg::IDX_IST, 2'h0}, 32'h3, "set wins over clear");
        wr(ppd_pkg::IDX_ICL, 32'h1);
        rd_chk({22'h0, ppd_pkg::IDX_IST, 2'h0}, 32'h2, "clear after event");
        check(loss_of_lock_alarm, 1'b1, "alarm on second unlock");
        $display("test alarm and interrupt done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
